//--- core/pat_device.sv
module pat_device
    import pat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Walker and software side
    pat_link.dev link,
    // Range register results for the current access
    input wire mem_type_t range_type,
    input wire logic range_enable,
    // Memory routing controls
    input wire logic route_enable,
    input wire logic route_rd_mem,
    input wire logic route_wr_mem,
    input wire logic acc_write,
    // Physical access
    output logic acc_valid,
    output logic [PADDR_WIDTH-1:0] acc_addr,
    output mem_type_t acc_type,
    output logic acc_table_fetch,
    output logic acc_to_mmio,
    // Status
    output mem_type_t last_type,
    output logic [2:0] last_index
);

    // =====================================================
    // Attribute register and per-slot decode
    // =====================================================
    logic [63:0] attr;
    logic [TYPE_WIDTH-1:0] slot_code [SLOT_COUNT];
    logic [SLOT_COUNT-1:0] rsvd_bad;
    logic [SLOT_COUNT-1:0] code_bad;
    logic [SLOT_COUNT-1:0] slot_bad;
    logic wr_bad;

    for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
        assign slot_code[g] = attr[g*SLOT_WIDTH +: TYPE_WIDTH];

        // Reserved bits of a written slot must be zero
        assign rsvd_bad[g] =
            |link.attr_wr_data[g*SLOT_WIDTH+TYPE_WIDTH +: RSVD_WIDTH];

        // Codes 2 and 3 name no memory type
        assign code_bad[g] =
            !code_ok(link.attr_wr_data[g*SLOT_WIDTH +: TYPE_WIDTH]);

        assign slot_bad[g] = rsvd_bad[g] || code_bad[g];
    end

    // One bad slot refuses the whole word
    assign wr_bad = |slot_bad;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            attr <= ATTR_RESET;
        end else if (link.attr_wr_valid && !wr_bad) begin
            // Only a word with no bad slot is taken
            attr <= link.attr_wr_data;
        end
    end

    assign link.attr_rd_data = attr;

    // =====================================================
    // Write answer
    // =====================================================
    // Both answers stand for one cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.attr_wr_done <= 1'b0;
        end else begin
            link.attr_wr_done <= link.attr_wr_valid;
        end
    end

    // Raised with done when the word was refused
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.attr_wr_fault <= 1'b0;
        end else begin
            link.attr_wr_fault <= link.attr_wr_valid && wr_bad;
        end
    end

    // =====================================================
    // Feature query
    // =====================================================
    logic query_hit;
    logic [31:0] query_word;

    assign query_hit = (link.query_func == QUERY_FUNC_STD) ||
                       (link.query_func == QUERY_FUNC_EXT);

    // Every other result bit reads as zero
    always_comb begin
        query_word = 32'h00000000;
        query_word[FEATURE_ATTR_BIT] = query_hit;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.query_done <= 1'b0;
        end else begin
            link.query_done <= link.query_valid;
        end
    end

    // The result holds until the next query
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.query_result <= 32'h00000000;
        end else if (link.query_valid) begin
            link.query_result <= query_word;
        end
    end

    // =====================================================
    // Index formation
    // =====================================================
    logic leaf_high;
    logic dir_high;
    logic cd_bit;
    logic wt_bit;

    logic idx_high;
    logic [2:0] idx;
    mem_type_t slot_type;
    mem_type_t eff_type;

    assign leaf_high = link.req_entry[LEAF_IDX_HIGH_POS];
    assign dir_high = link.req_entry[DIR_IDX_HIGH_POS];

    // Same place in every entry format
    assign cd_bit = link.req_entry[CACHE_DIS_POS];
    assign wt_bit = link.req_entry[WRITE_THRU_POS];

    always_comb begin
        unique case (link.req_level)
            lvl_leaf_small: idx_high = leaf_high;
            lvl_dir_large: idx_high = dir_high;
            // Upper levels carry no index-high bit, so only slots 0 to 3 are reachable
            lvl_upper: idx_high = 1'b0;
            default: idx_high = 1'b0;
        endcase
    end

    // The lookup has no enable of any kind: every request is indexed
    assign idx = {idx_high, cd_bit, wt_bit};

    // Refused writes keep codes 2 and 3 out, so the cast is safe
    assign slot_type = mem_type_t'(slot_code[idx]);

    type_combiner u_combiner (
        .slot_type(slot_type),
        .range_type(range_type),
        .range_enable(range_enable),
        .eff_type(eff_type)
    );

    // =====================================================
    // Physical access, same cycle as the request
    // =====================================================
    assign acc_valid = link.req_valid;
    assign acc_addr = link.req_paddr;
    assign acc_type = eff_type;
    // Table fetches reach slots 0 to 3 through the zero high bit
    assign acc_table_fetch = (link.req_level == lvl_upper);
    assign link.rsp_type = eff_type;

    logic route_mem;

    // Reads and writes each have their own memory control
    assign route_mem = acc_write ? route_wr_mem : route_rd_mem;

    // Routing falls back to memory-mapped I/O while disabled
    always_comb begin
        if (!route_enable) begin
            acc_to_mmio = 1'b1;
        end else begin
            acc_to_mmio = !route_mem;
        end
    end

    // =====================================================
    // Status of the last lookup
    // =====================================================
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_type <= mt_uncached;
        end else if (link.req_valid) begin
            last_type <= eff_type;
        end
    end

    // Slot chosen by the last request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_index <= 3'h0;
        end else if (link.req_valid) begin
            last_index <= idx;
        end
    end

endmodule

//--- core/pat_host.sv
module pat_host
    import pat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Device side
    pat_link.host link,
    // Walk requests
    input wire logic walk_valid,
    input wire entry_level_t walk_level,
    input wire logic [63:0] walk_entry,
    input wire logic [PADDR_WIDTH-1:0] walk_paddr,
    output mem_type_t walk_type,
    // Attribute writes
    input wire logic cfg_wr_valid,
    input wire logic [63:0] cfg_wr_data,
    output logic cfg_wr_done,
    output logic cfg_wr_fault,
    output logic [63:0] cfg_attr,
    // Feature report
    output logic attr_supported,
    output logic query_finished,
    // Type change sequencing
    input wire logic remap_start,
    input wire mem_type_t remap_old_type,
    input wire mem_type_t remap_new_type,
    output logic remap_busy,
    output logic unmap_pulse,
    output logic tlb_flush_pulse,
    output logic cache_flush_pulse,
    output logic install_pulse
);

    typedef enum logic [2:0] {st_idle, st_unmap, st_tlb, st_cache, st_install} remap_state_t;

    remap_state_t state;
    logic need_flush;
    logic query_pending;

    // =====================================================
    // Pass-through of walks and writes
    // =====================================================
    assign link.req_valid = walk_valid;
    assign link.req_level = walk_level;
    assign link.req_entry = walk_entry;
    assign link.req_paddr = walk_paddr;
    assign walk_type = link.rsp_type;
    // One writer per device; keeping copies identical is left to the caller
    assign link.attr_wr_valid = cfg_wr_valid;
    assign link.attr_wr_data = cfg_wr_data;
    assign cfg_wr_done = link.attr_wr_done;
    assign cfg_wr_fault = link.attr_wr_fault;
    assign cfg_attr = link.attr_rd_data;

    // =====================================================
    // Feature query once after reset
    // =====================================================
    assign link.query_valid = query_pending;
    assign link.query_func = QUERY_FUNC_STD;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            query_pending <= 1'b1;
            query_finished <= 1'b0;
            attr_supported <= 1'b0;
        end else begin
            query_pending <= 1'b0;
            if (link.query_done) begin
                query_finished <= 1'b1;
                attr_supported <= link.query_result[FEATURE_ATTR_BIT];
            end
        end
    end

    // =====================================================
    // Type change sequence
    // =====================================================
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= st_idle;
            need_flush <= 1'b0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (remap_start) begin
                        state <= st_unmap;
                        need_flush <= is_cacheable(remap_old_type) &&
                                      !is_cacheable(remap_new_type);
                    end
                end
                st_unmap: state <= st_tlb;
                st_tlb: state <= need_flush ? st_cache : st_install;
                st_cache: state <= st_install;
                st_install: state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    assign remap_busy = (state != st_idle);
    assign unmap_pulse = (state == st_unmap);
    assign tlb_flush_pulse = (state == st_tlb);
    assign cache_flush_pulse = (state == st_cache);
    assign install_pulse = (state == st_install);

endmodule

//--- core/pat_link.sv
interface pat_link;
    import pat_pkg::*;

    logic req_valid;
    entry_level_t req_level;
    logic [63:0] req_entry;
    logic [PADDR_WIDTH-1:0] req_paddr;
    mem_type_t rsp_type;
    logic attr_wr_valid;
    logic [63:0] attr_wr_data;
    logic attr_wr_fault;
    logic attr_wr_done;
    logic [63:0] attr_rd_data;
    logic query_valid;
    logic [31:0] query_func;
    logic query_done;
    logic [31:0] query_result;

    modport dev (
        input req_valid, req_level, req_entry, req_paddr,
        output rsp_type,
        input attr_wr_valid, attr_wr_data,
        output attr_wr_fault, attr_wr_done, attr_rd_data,
        input query_valid, query_func,
        output query_done, query_result
    );

    modport host (
        output req_valid, req_level, req_entry, req_paddr,
        input rsp_type,
        output attr_wr_valid, attr_wr_data,
        input attr_wr_fault, attr_wr_done, attr_rd_data,
        output query_valid, query_func,
        input query_done, query_result
    );

endinterface

//--- core/pat_pkg.sv
// Contract
// - Index-high bit: leaf bit 7, large-directory bit 12.
// - Entries lacking index-high bit use zero.
// - Cache-disable bit is entry bit 4.
// - Write-through bit is entry bit 3.
// - Index is high, cache-disable, write-through bits.
// - Reset slots: writeback, writethrough, overridable-uncached, uncached, twice.
// - Slot codes 00,01,04,05,06,07 hex only.
// - Reserved bits or bad code fault the write.
// - Feature query functions 1, 8000_0001h set bit 16.
// - Slot lookup always on, never disabled.
// - Every translated access uses its indexed slot type.
// - Upper-level fetches index slots 0 to 3 only.
// - Uncached, overridable-uncached, write-combining slot combination.
// - Write-protect, writethrough, writeback slot combination.
// - Range mechanism disabled means range type uncached.
// - Software keeps attribute state identical across processors.
// - Never map one page with two types.
// - Type change: unmap, flush translations, then install.
// - Cacheable to uncacheable change also flushes caches.
// - Routing disabled sends accesses to memory-mapped I/O.
package pat_pkg;

    typedef enum logic [2:0] {
        mt_uncached = 3'h0,
        mt_write_combining = 3'h1,
        mt_writethrough = 3'h4,
        mt_write_protect = 3'h5,
        mt_writeback = 3'h6,
        mt_overridable_uncached = 3'h7
    } mem_type_t;

    typedef enum logic [1:0] {
        lvl_leaf_small,
        lvl_dir_large,
        lvl_upper
    } entry_level_t;

    localparam int SLOT_COUNT = 8;
    localparam int SLOT_WIDTH = 8;
    localparam int TYPE_WIDTH = 3;
    localparam int RSVD_WIDTH = 5;
    localparam int PADDR_WIDTH = 52;
    localparam int LEAF_IDX_HIGH_POS = 7;
    localparam int DIR_IDX_HIGH_POS = 12;
    localparam int CACHE_DIS_POS = 4;
    localparam int WRITE_THRU_POS = 3;
    localparam logic [63:0] ATTR_RESET = 64'h0007040600070406;
    localparam int FEATURE_ATTR_BIT = 16;
    localparam logic [31:0] QUERY_FUNC_STD = 32'h00000001;
    localparam logic [31:0] QUERY_FUNC_EXT = 32'h80000001;

    function automatic logic code_ok(input logic [2:0] code);
        return (code != 3'h2) && (code != 3'h3);
    endfunction

    function automatic logic is_cacheable(input mem_type_t t);
        return (t == mt_writeback) || (t == mt_writethrough) || (t == mt_write_protect);
    endfunction

endpackage

//--- core/type_combiner.sv
module type_combiner
    import pat_pkg::*;
(
    // Inputs
    input wire mem_type_t slot_type,
    input wire mem_type_t range_type,
    input wire logic range_enable,
    // Result
    output mem_type_t eff_type
);

    mem_type_t rng;

    // =====================================================
    // Range type and combination
    // =====================================================
    always_comb begin
        rng = range_enable ? range_type : mt_uncached;
        eff_type = mt_uncached;
        unique case (slot_type)
            mt_uncached: eff_type = mt_uncached;
            mt_overridable_uncached: begin
                eff_type = (rng == mt_write_combining) ? mt_write_combining
                                                       : mt_uncached;
            end
            mt_write_combining: eff_type = mt_write_combining;
            mt_write_protect: begin
                if (rng == mt_write_protect || rng == mt_writeback) begin
                    eff_type = mt_write_protect;
                end else begin
                    eff_type = mt_uncached;
                end
            end
            mt_writethrough: begin
                if (rng == mt_writethrough || rng == mt_writeback) begin
                    eff_type = mt_writethrough;
                end else begin
                    eff_type = mt_uncached;
                end
            end
            mt_writeback: begin
                // An overridable-uncached range code falls back to uncached; any other range code passes through
                if (rng == mt_overridable_uncached) begin
                    eff_type = mt_uncached;
                end else begin
                    eff_type = rng;
                end
            end
            default: eff_type = mt_uncached;
        endcase
    end

endmodule

//--- tb/pat_checker_properties.sv
module pat_checker
    import pat_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link signals
    input wire logic req_valid,
    input wire entry_level_t req_level,
    input wire logic [63:0] req_entry,
    input wire mem_type_t rsp_type,
    input wire logic attr_wr_valid,
    input wire logic [63:0] attr_wr_data,
    input wire logic attr_wr_fault,
    input wire logic attr_wr_done,
    input wire logic [63:0] attr_rd_data,
    input wire logic query_valid,
    input wire logic [31:0] query_func,
    input wire logic query_done,
    input wire logic [31:0] query_result
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] idx;
    logic [2:0] slot_code;
    logic wr_bad;
    // ========================================
    // Slot selected by the current request
    always_comb begin
        idx[2] = (req_level == lvl_leaf_small) ? req_entry[7] :
            (req_level == lvl_dir_large) ? req_entry[12] : 1'b0;
        idx[1:0] = req_entry[4:3];
        slot_code = attr_rd_data[8*idx +: 3];
        wr_bad = 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr_bad |= (attr_wr_data[8*i+3 +: 5] != 5'h00) || (attr_wr_data[8*i+1 +: 2] == 2'h1);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ========================================
    // Properties
    property p_reset_slots;
        $rose(rst_b) |-> attr_rd_data == 64'h0007040600070406;
    endproperty
    a_reset_slots: assert property (p_reset_slots) else $error("bad reset slots");
    property p_wr_done;
        attr_wr_valid |=> attr_wr_done;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write not answered");
    property p_wr_fault;
        attr_wr_valid && wr_bad |=> attr_wr_fault && $stable(attr_rd_data);
    endproperty
    a_wr_fault: assert property (p_wr_fault) else $error("bad write taken");
    property p_wr_ok;
        attr_wr_valid && !wr_bad |=> !attr_wr_fault && attr_rd_data == $past(attr_wr_data);
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("good write lost");
    property p_query;
        query_valid && (query_func == 32'h1 || query_func == 32'h80000001)
            |=> query_done && query_result[16];
    endproperty
    a_query: assert property (p_query) else $error("support not reported");
    property p_query_cause;
        query_done |-> $past(query_valid);
    endproperty
    a_query_cause: assert property (p_query_cause) else $error("stray query answer");
    property p_uc_slot;
        req_valid && slot_code == 3'h0 |-> rsp_type == mt_uncached;
    endproperty
    a_uc_slot: assert property (p_uc_slot) else $error("uncached slot overridden");
    property p_wc_slot;
        req_valid && slot_code == 3'h1 |-> rsp_type == mt_write_combining;
    endproperty
    a_wc_slot: assert property (p_wc_slot) else $error("combining slot lost");
    property p_ucm_slot;
        req_valid && slot_code == 3'h7 |-> rsp_type inside {mt_uncached, mt_write_combining};
    endproperty
    a_ucm_slot: assert property (p_ucm_slot) else $error("minus slot cached");
endmodule

//--- tb/tb_page_attr_memory_type_resolver.sv
module tb_page_attr_memory_type_resolver;
    import pat_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, range_enable, route_enable, route_rd_mem, route_wr_mem, acc_write;
    logic acc_valid, acc_to_mmio, walk_valid, cfg_wr_valid, cfg_wr_done, cfg_wr_fault;
    logic attr_supported, remap_start, remap_busy, unmap_pulse, tlb_flush_pulse;
    logic cache_flush_pulse, install_pulse, acc_table_fetch, query_finished;
    logic [2:0] last_index;
    logic [PADDR_WIDTH-1:0] acc_addr, walk_paddr;
    logic [63:0] walk_entry, cfg_wr_data, cfg_attr;
    mem_type_t range_type, acc_type, last_type, walk_type, remap_old_type, remap_new_type;
    entry_level_t walk_level;
    int fails, cmp_count;
    pat_link link_if ();
    pat_device pat_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if.dev),
        .range_type(range_type), .range_enable(range_enable), .route_enable(route_enable),
        .route_rd_mem(route_rd_mem), .route_wr_mem(route_wr_mem), .acc_write(acc_write),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_type(acc_type),
        .acc_table_fetch(acc_table_fetch), .acc_to_mmio(acc_to_mmio), .last_type(last_type),
        .last_index(last_index));
    pat_host pat_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if.host),
        .walk_valid(walk_valid), .walk_level(walk_level), .walk_entry(walk_entry),
        .walk_paddr(walk_paddr), .walk_type(walk_type), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_data(cfg_wr_data), .cfg_wr_done(cfg_wr_done), .cfg_wr_fault(cfg_wr_fault),
        .cfg_attr(cfg_attr), .attr_supported(attr_supported), .query_finished(query_finished),
        .remap_start(remap_start), .remap_old_type(remap_old_type),
        .remap_new_type(remap_new_type), .remap_busy(remap_busy), .unmap_pulse(unmap_pulse),
        .tlb_flush_pulse(tlb_flush_pulse), .cache_flush_pulse(cache_flush_pulse),
        .install_pulse(install_pulse));
    pat_checker pat_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
        .req_valid(link_if.req_valid), .req_level(link_if.req_level),
        .req_entry(link_if.req_entry), .rsp_type(link_if.rsp_type),
        .attr_wr_valid(link_if.attr_wr_valid), .attr_wr_data(link_if.attr_wr_data),
        .attr_wr_fault(link_if.attr_wr_fault), .attr_wr_done(link_if.attr_wr_done),
        .attr_rd_data(link_if.attr_rd_data), .query_valid(link_if.query_valid),
        .query_func(link_if.query_func), .query_done(link_if.query_done),
        .query_result(link_if.query_result));
    // ========================================
    // Helpers
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [63:0] mk(input logic b12, input logic b7, input logic [1:0] lo);
        return {51'h0, b12, 4'h0, b7, 2'h0, lo, 3'h0};
    endfunction
    function automatic mem_type_t exp_type(input mem_type_t s, input mem_type_t r);
        case (s)
            mt_uncached: return mt_uncached;
            mt_overridable_uncached: return (r == mt_write_combining) ? r : mt_uncached;
            mt_write_combining: return mt_write_combining;
            mt_write_protect: return (r inside {mt_write_protect, mt_writeback}) ? s : mt_uncached;
            mt_writethrough: return (r inside {mt_writethrough, mt_writeback}) ? s : mt_uncached;
            default: return r;
        endcase
    endfunction
    task automatic look(input entry_level_t lv, input logic [63:0] e, input mem_type_t exp);
        logic [2:0] ix;
        ix = {lv == lvl_leaf_small ? e[7] : lv == lvl_dir_large && e[12], e[4:3]};
        walk_level = lv;
        walk_entry = e;
        walk_paddr = e[PADDR_WIDTH-1:0] ^ 52'h5a5a5a5a5a5a5;
        #1;
        check(walk_type === exp && acc_type === exp, "lookup type");
        check(acc_valid === 1'b1 && acc_addr === walk_paddr, "access address");
        check(acc_table_fetch === (lv == lvl_upper), "fetch flag");
        @(negedge core_clk);
        check(last_type === exp, "last type");
        check(last_index === ix, "last index");
    endtask
    task automatic wr(input logic [63:0] d, input logic bad);
        logic [63:0] old;
        old = cfg_attr;
        cfg_wr_data = d;
        cfg_wr_valid = 1'b1;
        @(negedge core_clk);
        cfg_wr_valid = 1'b0;
        check(cfg_wr_done === 1'b1 && cfg_wr_fault === bad, "write answer");
        check(cfg_attr === (bad ? old : d), "attribute contents");
        @(negedge core_clk);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        check(cfg_attr === 64'h0007040600070406, "reset slots");
        for (int n = 0; n < 10 && attr_supported !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        check(attr_supported === 1'b1 && query_finished === 1'b1, "support flag");
        range_type = mt_write_combining;
        look(lvl_leaf_small, mk(1'b0, 1'b1, 2'h2), mt_write_combining);
        look(lvl_leaf_small, mk(1'b0, 1'b1, 2'h3), mt_uncached);
    endtask
    task automatic t_index();
        mem_type_t tbl [8] = '{mt_writeback, mt_writethrough, mt_uncached, mt_uncached,
            mt_write_combining, mt_write_protect, mt_writethrough, mt_write_protect};
        wr(64'h0504050100070406, 1'b0);
        range_type = mt_writeback;
        for (int i = 0; i < 8; i++) begin
            look(lvl_leaf_small, mk(!i[2], i[2], i[1:0]), tbl[i]);
            look(lvl_dir_large, mk(i[2], !i[2], i[1:0]), tbl[i]);
            look(lvl_upper, mk(1'b1, 1'b1, i[1:0]), tbl[i%4]);
        end
    endtask
    task automatic t_combine();
        mem_type_t sl [6] = '{mt_uncached, mt_overridable_uncached, mt_write_combining,
            mt_write_protect, mt_writethrough, mt_writeback};
        mem_type_t rg [5] = '{mt_uncached, mt_write_combining, mt_writethrough,
            mt_write_protect, mt_writeback};
        wr(64'h0000060405010700, 1'b0);
        for (int s = 0; s < 6; s++) begin
            range_enable = 1'b1;
            for (int r = 0; r < 5; r++) begin
                range_type = rg[r];
                look(lvl_leaf_small, mk(1'b0, s[2], s[1:0]), exp_type(sl[s], rg[r]));
            end
            range_enable = 1'b0;
            look(lvl_leaf_small, mk(1'b0, s[2], s[1:0]), exp_type(sl[s], mt_uncached));
        end
        range_enable = 1'b1;
    endtask
    task automatic t_fault();
        wr(64'h0000000000000008, 1'b1);
        wr(64'h0200000000000000, 1'b1);
        wr(64'h0000000000000300, 1'b1);
        wr(64'h0000000000000000, 1'b0);
    endtask
    task automatic t_route();
        route_enable = 1'b0;
        #1;
        check(acc_to_mmio === 1'b1, "routing off");
        @(negedge core_clk);
        route_enable = 1'b1;
        #1;
        check(acc_to_mmio === 1'b0, "read to memory");
        @(negedge core_clk);
        acc_write = 1'b1;
        #1;
        check(acc_to_mmio === 1'b1, "write to io");
        @(negedge core_clk);
        route_wr_mem = 1'b1;
        #1;
        check(acc_to_mmio === 1'b0, "write to memory");
        @(negedge core_clk);
    endtask
    task automatic t_remap(input mem_type_t o, input mem_type_t n, input logic fl);
        int seen [4];
        remap_old_type = o;
        remap_new_type = n;
        remap_start = 1'b1;
        @(negedge core_clk);
        remap_start = 1'b0;
        for (int c = 1; c < 8; c++) begin
            seen[0] += (unmap_pulse === 1'b1) ? c : 0;
            seen[1] += (tlb_flush_pulse === 1'b1) ? c : 0;
            seen[2] += (cache_flush_pulse === 1'b1) ? c : 0;
            seen[3] += (install_pulse === 1'b1) ? c : 0;
            @(negedge core_clk);
        end
        check(seen[0] == 1 && seen[1] == 2 && seen[3] == 3 + fl, "remap order");
        check(seen[2] == (fl ? 3 : 0) && remap_busy === 1'b0, "cache flush");
    endtask
    // ========================================
    // Clock and main sequence
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        {rst_b, walk_valid, cfg_wr_valid, remap_start, acc_write, route_wr_mem} = '0;
        {range_enable, route_enable, route_rd_mem} = '1;
        {fails, cmp_count} = '0;
        range_type = mt_writeback;
        walk_level = lvl_leaf_small;
        {walk_entry, walk_paddr, cfg_wr_data} = '0;
        remap_old_type = mt_uncached;
        remap_new_type = mt_uncached;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        walk_valid = 1'b1;
        t_reset();
        t_index();
        t_combine();
        t_fault();
        t_route();
        t_remap(mt_writeback, mt_uncached, 1'b1);
        t_remap(mt_uncached, mt_writeback, 1'b0);
        t_remap(mt_writethrough, mt_write_combining, 1'b1);
        t_remap(mt_write_protect, mt_writethrough, 1'b0);
        conclude();
    end
endmodule
